// ### core/clkodv_phase_gen.sv
// Phase generator: full, half and quarter rate waveforms of the system clock
`timescale 1ns/1ps
`include "clkodv_params.svh"

module clkodv_phase_gen
  import clkodv_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  // Phases
  output clkodv_phase_s      o_phase
);

  logic [`CLKODV_CNT_W-1:0] cnt_q;
  logic [`CLKODV_CNT_W-1:0] cnt_d;
  logic                     neg_copy_q;

  assign cnt_d = cnt_q + `CLKODV_CNT_W'(1);

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Falling-edge copy of bit 0; the XOR with bit 0 is high for the first
  // half of every system clock period, a full rate clock built from flops
  always_ff @(negedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      neg_copy_q <= 1'b0;
    end else begin
      neg_copy_q <= cnt_q[0];
    end
  end

  assign o_phase.full    = cnt_q[0] ^ neg_copy_q;
  assign o_phase.half    = cnt_q[0];
  assign o_phase.quarter = cnt_q[1];
  assign o_phase.cnt     = cnt_q;

endmodule

// ### core/clkodv_top.sv
// External clock output divider: divide-select field and output pin drive
`timescale 1ns/1ps
`include "clkodv_params.svh"

module clkodv_top
  import clkodv_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  // Clock-output control field write
  input  wire clkodv_ctrl_s  i_clock_out_control,
  // Field readback and selection in force
  output clkodv_sel_e        o_clock_out_divide_sel,
  output clkodv_sel_e        o_sel_active,
  // External clock output pin
  output clkodv_pin_s        o_ext_clock_out
);

  // Reset selection, kept in step with the header constant
  localparam clkodv_sel_e SEL_RESET = clkodv_sel_e'(`CLKODV_SEL_RESET);

  // Bit positions of the one-hot selection view
  localparam int HOT_DIV4 = 0;
  localparam int HOT_DIV2 = 1;
  localparam int HOT_DIV1 = 2;
  localparam int HOT_OFF  = 3;

  // Field write request split out of the carrier
  logic          wr_req;
  clkodv_sel_e   wr_value;

  // Stored field and the selection that drives the pin
  clkodv_sel_e   sel_q;
  clkodv_sel_e   sel_d;
  clkodv_sel_e   act_q;
  clkodv_sel_e   act_d;

  // Decoded views and switch timing
  logic [3:0]    field_hot;
  logic [3:0]    act_hot;
  clkodv_phase_s phase;
  logic          at_boundary;
  logic          switch_pending;
  logic          take_field;

  // Pin drive
  logic          pin_level;
  logic          pin_off;
  logic          pin_out;
  logic          pin_oe;

  // selection code decode
  // Unknown codes decode as off: a corrupted field can only silence the pin
  function automatic logic [3:0] clkodv_decode(input clkodv_sel_e sel);
    logic [3:0] hot;
    hot = 4'h0;
    case (sel)
      CLKODV_DIV4: begin
        hot[HOT_DIV4] = 1'b1;
      end
      CLKODV_DIV2: begin
        hot[HOT_DIV2] = 1'b1;
      end
      CLKODV_DIV1: begin
        hot[HOT_DIV1] = 1'b1;
      end
      CLKODV_OFF: begin
        hot[HOT_OFF] = 1'b1;
      end
      default: begin
        hot[HOT_OFF] = 1'b1;
      end
    endcase
    return hot;
  endfunction

  // Next field value: a write replaces it, otherwise it holds
  function automatic clkodv_sel_e clkodv_next_field(input logic        wr,
                                                    input clkodv_sel_e value,
                                                    input clkodv_sel_e held);
    clkodv_sel_e nxt;
    nxt = held;
    if (wr) begin
      nxt = value;
    end
    return nxt;
  endfunction

  // pin level for a decoded selection
  function automatic logic clkodv_level(input logic [3:0] hot, input clkodv_phase_s ph);
    logic lvl;
    lvl = 1'b0;
    if (hot[HOT_DIV4]) begin
      lvl = ph.quarter;
    end else if (hot[HOT_DIV2]) begin
      lvl = ph.half;
    end else if (hot[HOT_DIV1]) begin
      lvl = ph.full;
    end else begin
      lvl = 1'b0;
    end
    return lvl;
  endfunction

  // Last count of a quarter-rate period: quarter and half fall at the next edge
  function automatic logic clkodv_is_last(input logic [`CLKODV_CNT_W-1:0] cnt);
    return (cnt == `CLKODV_CNT_LAST);
  endfunction

  clkodv_phase_gen u_phase (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .o_phase   (phase)
  );

  // Field write; the stored value is what software reads back
  assign wr_req   = i_clock_out_control.wr;
  assign wr_value = i_clock_out_control.sel;
  assign sel_d    = clkodv_next_field(wr_req, wr_value, sel_q);

  // Switch timing, over the counts of the free phase counter:
  //   count  0 1 2 3 | 0
  //   div4   0 0 1 1 | 0
  //   div2   0 1 0 1 | 0
  //   div1   one pulse in the first half of every period
  // Quarter and half both fall at the edge after count 3, so a change among
  // div4, div2 and off there lands on the old rate's own fall, one into div1 opens with a
  // whole first-half pulse, and the pin shows no runt pulse.
  // The trade is up to four cycles between a write and the new rate.
  assign field_hot      = clkodv_decode(sel_q);
  assign act_hot        = clkodv_decode(act_q);
  assign at_boundary    = clkodv_is_last(phase.cnt);
  assign switch_pending = (field_hot != act_hot);
  assign take_field     = at_boundary && switch_pending;
  assign act_d          = take_field ? sel_q : act_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_q <= SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      act_q <= SEL_RESET;
    end else begin
      act_q <= act_d;
    end
  end

  assign pin_level = clkodv_level(act_hot, phase);

  assign pin_off = act_hot[HOT_OFF];
  assign pin_out = pin_level & ~pin_off;

  // pin always driven
  // The enable ignores reset, so board logic never sees a floating clock
  assign pin_oe = 1'b1;

  assign o_ext_clock_out        = '{out: pin_out, oe: pin_oe};
  assign o_clock_out_divide_sel = sel_q;
  assign o_sel_active           = act_q;

endmodule

// ### inc/clkodv_params.svh
// Constants for the external clock output divider
`ifndef CLKODV_PARAMS_SVH
`define CLKODV_PARAMS_SVH

// Divide-select field encoding
`define CLKODV_SEL_DIV4  2'h0
`define CLKODV_SEL_DIV2  2'h1
`define CLKODV_SEL_DIV1  2'h2
`define CLKODV_SEL_OFF   2'h3

// Field reset value: quarter rate
`define CLKODV_SEL_RESET `CLKODV_SEL_DIV4

// Phase counter width and the count at which a new selection may take effect
`define CLKODV_CNT_W     2
`define CLKODV_CNT_LAST  2'h3

`endif

// ### inc/clkodv_pkg.sv
// Types for the external clock output divider
package clkodv_pkg;

`include "clkodv_params.svh"

  typedef enum logic [1:0] {
    CLKODV_DIV4 = 2'b00,
    CLKODV_DIV2 = 2'b01,
    CLKODV_DIV1 = 2'b10,
    CLKODV_OFF  = 2'b11
  } clkodv_sel_e;

  // Write into the clock-output control field
  typedef struct packed {
    logic        wr;
    clkodv_sel_e sel;
  } clkodv_ctrl_s;

  // Output pin as three-state signals
  typedef struct packed {
    logic out;
    logic oe;
  } clkodv_pin_s;

  // Phases produced by the phase generator
  typedef struct packed {
    logic                     full;
    logic                     half;
    logic                     quarter;
    logic [`CLKODV_CNT_W-1:0] cnt;
  } clkodv_phase_s;

endpackage

// ### verif/clkodv_board.sv
// Board model counting output clock rises
`timescale 1ns/1ps
module clkodv_board
  import clkodv_pkg::*;
(
  input  logic        i_clr,
  input  clkodv_pin_s i_pin,
  output int          o_edges
);
  always @(posedge i_pin.out or posedge i_clr)
    o_edges <= i_clr ? 0 : o_edges + 1;
endmodule

// ### verif/clkodv_monitor.sv
// Port checker for the clock output divider
`timescale 1ns/1ps
module clkodv_monitor
  import clkodv_pkg::*;
(
  // Watched ports
  input logic         i_clk_sys,
  input logic         i_rstn,
  input clkodv_ctrl_s i_clock_out_control,
  input clkodv_sel_e  o_clock_out_divide_sel,
  input clkodv_sel_e  o_sel_active,
  input clkodv_pin_s  o_ext_clock_out
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_field_reset: assert property ($rose(i_rstn) |-> o_clock_out_divide_sel == 2'h0)
    else $error("bad reset");
  a_field_write: assert property (i_clock_out_control.wr |=>
    o_clock_out_divide_sel == $past(i_clock_out_control.sel)) else $error("lost write");
  a_off_low: assert property (o_sel_active == 2'h3 |-> !o_ext_clock_out.out)
    else $error("off toggles");
  a_half_rate: assert property (o_sel_active == 2'h1 && $past(o_sel_active) == 2'h1
    |-> $changed(o_ext_clock_out.out)) else $error("div2 stuck");
  a_pin_driven: assert property (disable iff (1'b0) o_ext_clock_out.oe) else $error("released");
  // Field change and the pin selection catching up with it
  sequence s_field_moved;
    $changed(o_clock_out_divide_sel);
  endsequence
  sequence s_caught_up;
    (o_sel_active == o_clock_out_divide_sel) || $changed(o_clock_out_divide_sel);
  endsequence
  a_switch_prompt: assert property (s_field_moved |-> ##[1:4] s_caught_up)
    else $error("switch late");
  a_switch_follow: assert property ($changed(o_sel_active) |->
    o_sel_active == $past(o_clock_out_divide_sel)) else $error("switch wrong");
endmodule
bind clkodv_top clkodv_monitor u_mon (
  .i_clk_sys              (i_clk_sys),
  .i_rstn                 (i_rstn),
  .i_clock_out_control    (i_clock_out_control),
  .o_clock_out_divide_sel (o_clock_out_divide_sel),
  .o_sel_active           (o_sel_active),
  .o_ext_clock_out        (o_ext_clock_out)
);

// ### verif/tb_top.sv
// Testbench for the clock output divider
`timescale 1ns/1ps
module tb_top;
  import clkodv_pkg::*;
  logic         clk = 1'b0, rstn = 1'b0, clr = 1'b0;
  clkodv_ctrl_s c = '0;
  clkodv_sel_e  f;
  clkodv_sel_e  act;
  clkodv_pin_s  p;
  int           n, num_errors = 0, checks = 0, rows[4][2] = '{'{0, 4}, '{1, 8}, '{2, 16}, '{3, 0}};
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; $display("ERROR %0t %h %h", $time, a, e); end end
  always #2 clk = ~clk;
  clkodv_top u_dut(.i_clk_sys(clk), .i_rstn(rstn), .i_clock_out_control(c),
    .o_clock_out_divide_sel(f), .o_sel_active(act), .o_ext_clock_out(p));
  clkodv_board u_brd(.i_clr(clr), .i_pin(p), .o_edges(n));
  task go(input logic w, input int s, k);
    c = {w, s[1:0]};
    repeat (k) @(negedge clk);
  endtask
  task meas(input int e);
    clr = 1;
    @(negedge clk);
    clr = 0;
    repeat (16) @(negedge clk);
    `CHK(n, e)
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    go(0, 0, 8);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      go(1, rows[i][0], 1);
      go(0, rows[i][0], 5);
      `CHK(f, rows[i][0][1:0])
      `CHK(act, rows[i][0][1:0])
      meas(rows[i][1]);
    end
    // Back to back writes: the later one wins
    go(1, 2, 1);
    go(1, 3, 1);
    go(0, 3, 5);
    `CHK(f, 2'h3)
    `CHK(act, 2'h3)
    meas(0);
    rstn = 1'b0;
    go(0, 3, 1);
    `CHK(p.oe, 1'b1)
    `CHK(p.out, 1'b0)
    `CHK(f, 2'h0)
    rstn = 1'b1;
    `CHK(f, 2'h0)
    `CHK(act, 2'h0)
    meas(4);
    finish_test;
  end
endmodule
